//--- bsti_consts.vh
// constants for the boundary-scan instruction and data register block
`ifndef BSTI_CONSTS_VH
`define BSTI_CONSTS_VH
`define BSTI_IR_W          6
`define BSTI_OP_EXTEST     6'h00
`define BSTI_OP_SAMPLE     6'h01
`define BSTI_OP_IDCODE     6'h02
`define BSTI_OP_HIGHZ      6'h03
`define BSTI_OP_CAPTURE    6'h2D
`define BSTI_OP_CLAMP      6'h3E
`define BSTI_OP_BYPASS     6'h3F
`define BSTI_ID_W          32
`define BSTI_ID_ONE_POS    0
`define BSTI_MAKER_LSB     1
`define BSTI_MAKER_W       11
`define BSTI_PART_LSB      12
`define BSTI_PART_W        16
`define BSTI_REV_LSB       28
`define BSTI_REV_W         4
`define BSTI_TAP_RESET     4'h0
`define BSTI_TAP_IDLE      4'h1
`define BSTI_TAP_SEL_DR    4'h2
`define BSTI_TAP_CAP_DR    4'h3
`define BSTI_TAP_SHIFT_DR  4'h4
`define BSTI_TAP_EXIT1_DR  4'h5
`define BSTI_TAP_PAUSE_DR  4'h6
`define BSTI_TAP_EXIT2_DR  4'h7
`define BSTI_TAP_UPD_DR    4'h8
`define BSTI_TAP_SEL_IR    4'h9
`define BSTI_TAP_CAP_IR    4'hA
`define BSTI_TAP_SHIFT_IR  4'hB
`define BSTI_TAP_EXIT1_IR  4'hC
`define BSTI_TAP_PAUSE_IR  4'hD
`define BSTI_TAP_EXIT2_IR  4'hE
`define BSTI_TAP_UPD_IR    4'hF
`endif

//--- bsti_sync.v
// two-flop synchroniser bank for the test-port pins
`timescale 1ns/100ps
module bsti_sync #(
   parameter W = 4
) (
   // clock
   input  wire         i_clk_sys,
   input  wire         i_rst_b,
   input  wire         i_ce,
   // data
   input  wire [W-1:0] i_async,
   input  wire [W-1:0] i_rst_val,
   output reg  [W-1:0] o_sync
);
   reg [W-1:0] meta;
   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         meta   <= i_rst_val;
         o_sync <= i_rst_val;
      end else if (i_ce) begin
         meta   <= i_async;
         o_sync <= meta;
      end
   end
endmodule // bsti_sync

//--- bsti_tap.v
// boundary-scan test port: controller, instruction register, id and bypass paths
`timescale 1ns/100ps
`include "bsti_consts.vh"
module bsti_tap #(
   parameter [`BSTI_MAKER_W-1:0] MAKER_CODE = 11'h5A5,   // arbitrary value
   parameter [`BSTI_PART_W-1:0]  PART_CODE  = 16'h1234,  // arbitrary value
   parameter [`BSTI_REV_W-1:0]   REV_CODE   = 4'h1       // arbitrary value
) (
   // system clock
   input  wire       i_clk_sys,
   input  wire       i_rst_b,
   input  wire       i_ce,
   // test port pins
   input  wire       i_tck,
   input  wire       i_tms,
   input  wire       i_tdi,
   input  wire       i_trst_b,
   output reg        o_tdo,
   output reg        o_tdo_oe,
   // status toward the core
   output reg        o_clamp,
   output reg        o_highz,
   output reg  [5:0] o_instr,
   output reg  [3:0] o_tap_state
);
   wire [3:0] pins_s;
   bsti_sync #(.W(4)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_rst_b   (i_rst_b),
      .i_ce      (i_ce),
      .i_async   ({i_trst_b, i_tdi, i_tms, i_tck}),
      .i_rst_val (4'hE), // pins start at idle levels, so no false edge after reset
      .o_sync    (pins_s)
   );
   wire tck_s   = pins_s[0];
   wire tms_s   = pins_s[1];
   wire tdi_s   = pins_s[2];
   wire trst_bs = pins_s[3];

   reg        tck_d;
   reg  [3:0] state;
   reg  [3:0] next_state;
   reg  [5:0] ir_shift;
   reg  [31:0] id_shift;
   reg        bypass_bit;
   wire       tck_rise = tck_s & ~tck_d;
   wire       tck_fall = ~tck_s & tck_d;

   wire [31:0] id_value;
   assign id_value[`BSTI_ID_ONE_POS] = 1'b1;
   assign id_value[`BSTI_MAKER_LSB +: `BSTI_MAKER_W] = MAKER_CODE;
   assign id_value[`BSTI_PART_LSB +: `BSTI_PART_W]   = PART_CODE;
   assign id_value[`BSTI_REV_LSB +: `BSTI_REV_W]     = REV_CODE;

   // unknown and reserved codes fall to bypass so the chain stays intact
   wire sel_id = (o_instr == `BSTI_OP_IDCODE);
   wire sel_bp = ~sel_id;

   always @* begin
      case (state)
         `BSTI_TAP_RESET:     next_state = tms_s ? `BSTI_TAP_RESET    : `BSTI_TAP_IDLE;
         `BSTI_TAP_IDLE:      next_state = tms_s ? `BSTI_TAP_SEL_DR   : `BSTI_TAP_IDLE;
         `BSTI_TAP_SEL_DR:    next_state = tms_s ? `BSTI_TAP_SEL_IR   : `BSTI_TAP_CAP_DR;
         `BSTI_TAP_CAP_DR:    next_state = tms_s ? `BSTI_TAP_EXIT1_DR : `BSTI_TAP_SHIFT_DR;
         `BSTI_TAP_SHIFT_DR:  next_state = tms_s ? `BSTI_TAP_EXIT1_DR : `BSTI_TAP_SHIFT_DR;
         `BSTI_TAP_EXIT1_DR:  next_state = tms_s ? `BSTI_TAP_UPD_DR   : `BSTI_TAP_PAUSE_DR;
         `BSTI_TAP_PAUSE_DR:  next_state = tms_s ? `BSTI_TAP_EXIT2_DR : `BSTI_TAP_PAUSE_DR;
         `BSTI_TAP_EXIT2_DR:  next_state = tms_s ? `BSTI_TAP_UPD_DR   : `BSTI_TAP_SHIFT_DR;
         `BSTI_TAP_UPD_DR:    next_state = tms_s ? `BSTI_TAP_SEL_DR   : `BSTI_TAP_IDLE;
         `BSTI_TAP_SEL_IR:    next_state = tms_s ? `BSTI_TAP_RESET    : `BSTI_TAP_CAP_IR;
         `BSTI_TAP_CAP_IR:    next_state = tms_s ? `BSTI_TAP_EXIT1_IR : `BSTI_TAP_SHIFT_IR;
         `BSTI_TAP_SHIFT_IR:  next_state = tms_s ? `BSTI_TAP_EXIT1_IR : `BSTI_TAP_SHIFT_IR;
         `BSTI_TAP_EXIT1_IR:  next_state = tms_s ? `BSTI_TAP_UPD_IR   : `BSTI_TAP_PAUSE_IR;
         `BSTI_TAP_PAUSE_IR:  next_state = tms_s ? `BSTI_TAP_EXIT2_IR : `BSTI_TAP_PAUSE_IR;
         `BSTI_TAP_EXIT2_IR:  next_state = tms_s ? `BSTI_TAP_UPD_IR   : `BSTI_TAP_SHIFT_IR;
         `BSTI_TAP_UPD_IR:    next_state = tms_s ? `BSTI_TAP_SEL_DR   : `BSTI_TAP_IDLE;
         default:             next_state = `BSTI_TAP_RESET;
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         tck_d      <= 1'b0;
         state      <= `BSTI_TAP_RESET;
         o_instr    <= `BSTI_OP_IDCODE;
         ir_shift   <= 6'h00;
         id_shift   <= 32'h0000_0000;
         bypass_bit <= 1'b0;
         o_tdo      <= 1'b0;
         o_tdo_oe   <= 1'b0;
      end else if (i_ce) begin
         tck_d <= tck_s;
         if (!trst_bs) begin
            // test reset is asynchronous on the pin; here it acts within three system clocks
            state    <= `BSTI_TAP_RESET;
            o_instr  <= `BSTI_OP_IDCODE;
            o_tdo_oe <= 1'b0;
         end else if (tck_rise) begin
            state <= next_state;
            case (state)
               `BSTI_TAP_RESET:
                  o_instr <= `BSTI_OP_IDCODE;
               `BSTI_TAP_CAP_IR:
                  ir_shift <= `BSTI_OP_CAPTURE;
               `BSTI_TAP_SHIFT_IR:
                  ir_shift <= {tdi_s, ir_shift[5:1]};
               `BSTI_TAP_UPD_IR:
                  o_instr <= ir_shift;
               `BSTI_TAP_CAP_DR: begin
                  bypass_bit <= 1'b0;
                  id_shift   <= id_value;
               end
               `BSTI_TAP_SHIFT_DR: begin
                  bypass_bit <= tdi_s;
                  id_shift   <= {tdi_s, id_shift[31:1]};
               end
               default: begin
               end
            endcase
            // the instruction resets on entry, not a test clock later
            if (next_state == `BSTI_TAP_RESET)
               o_instr <= `BSTI_OP_IDCODE;
         end else if (tck_fall) begin
            // output changes on the falling edge so the tester samples a settled bit
            o_tdo_oe <= (state == `BSTI_TAP_SHIFT_DR) |
                        (state == `BSTI_TAP_SHIFT_IR);
            if (state == `BSTI_TAP_SHIFT_IR)
               o_tdo <= ir_shift[0];
            else if (sel_bp)
               o_tdo <= bypass_bit;
            else
               o_tdo <= id_shift[0];
         end
      end
   end

   always @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         o_clamp     <= 1'b0;
         o_highz     <= 1'b0;
         o_tap_state <= `BSTI_TAP_RESET;
      end else if (i_ce) begin
         o_clamp     <= (o_instr == `BSTI_OP_CLAMP);
         o_highz     <= (o_instr == `BSTI_OP_HIGHZ);
         o_tap_state <= state;
      end
   end
endmodule // bsti_tap

//--- bsti_tap_assertions.sv
// concurrent checks on the test-port block outputs
`timescale 1ns/100ps
`include "bsti_consts.vh"
module bsti_tap_assertions (
   input wire       i_clk_sys,
   input wire       i_rst_b,
   input wire       i_trst_b,
   input wire       o_tdo_oe,
   input wire       o_clamp,
   input wire       o_highz,
   input wire [5:0] o_instr,
   input wire [3:0] o_tap_state
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   a_reset_instr: assert property ($rose(i_rst_b) |-> o_instr == `BSTI_OP_IDCODE)
      else $error("instruction not id after reset");
   a_oe_shift: assert property (o_tdo_oe |-> o_tap_state inside {`BSTI_TAP_SHIFT_DR,
      `BSTI_TAP_EXIT1_DR, `BSTI_TAP_SHIFT_IR, `BSTI_TAP_EXIT1_IR}) else $error("oe outside shift");
   a_clamp_match: assert property ($stable(o_instr)[*2] |->
      o_clamp == (o_instr == `BSTI_OP_CLAMP)) else $error("clamp flag wrong");
   a_highz_match: assert property ($stable(o_instr)[*2] |->
      o_highz == (o_instr == `BSTI_OP_HIGHZ)) else $error("highz flag wrong");
   a_instr_update: assert property ($changed(o_instr) |-> ##[0:2]
      (o_tap_state == `BSTI_TAP_UPD_IR || o_tap_state == `BSTI_TAP_RESET))
      else $error("instruction changed outside update");
   a_reset_idle: assert property ($past(o_tap_state) == `BSTI_TAP_RESET && o_tap_state !=
      `BSTI_TAP_RESET |-> o_tap_state == `BSTI_TAP_IDLE) else $error("bad exit from reset");
   a_selir_next: assert property ($past(o_tap_state) == `BSTI_TAP_SEL_IR &&
      o_tap_state != `BSTI_TAP_SEL_IR |->
      o_tap_state inside {`BSTI_TAP_CAP_IR, `BSTI_TAP_RESET})
      else $error("bad exit from select-ir");
   a_trst_reset: assert property (!i_trst_b[*8] |-> o_tap_state == `BSTI_TAP_RESET
      && o_instr == `BSTI_OP_IDCODE && !o_tdo_oe) else $error("test reset not honoured");
endmodule // bsti_tap_assertions
bind bsti_tap bsti_tap_assertions i_chk (.i_clk_sys, .i_rst_b, .i_trst_b, .o_tdo_oe, .o_clamp,
   .o_highz, .o_instr, .o_tap_state);

//--- bsti_tap_tb_top.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/100ps
`include "bsti_consts.vh"
module bsti_tap_tb_top;
   localparam [31:0] ID = {4'h1, 16'h1234, 11'h5A5, 1'b1};
   logic        i_clk_sys;
   logic        i_rst_b;
   logic        ce = 1'b1;
   logic        o;
   logic [31:0] d;
   wire         tck, tms, tdi, trst_b, tdo, oe, clamp, highz;
   wire  [5:0]  instr;
   wire  [3:0]  state;
   int          n_mismatch = 0, num_checks = 0, cyc = 0, r;
   // only defined opcodes are loaded: {op, clamp, highz, first two dr bits}
   logic [9:0]  rows [5] = '{{6'h3F, 4'b0010}, {6'h3E, 4'b1010}, {6'h03, 4'b0110},
                             {6'h00, 4'b0010}, {6'h02, 4'b0011}};
   bsti_tap #(.MAKER_CODE(11'h5A5), .PART_CODE(16'h1234), .REV_CODE(4'h1)) i_dut (
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(ce), .i_tck(tck), .i_tms(tms),
      .i_tdi(tdi), .i_trst_b(trst_b), .o_tdo(tdo), .o_tdo_oe(oe), .o_clamp(clamp),
      .o_highz(highz), .o_instr(instr), .o_tap_state(state));
   bsti_tester i_tst (.i_clk_sys(i_clk_sys), .i_tdo(tdo), .o_tck(tck), .o_tms(tms),
      .o_tdi(tdi), .o_trst_b(trst_b));
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task final_report;
      if (n_mismatch == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // from idle: walk to shift, move n bits lsb first, update, back to idle
   task scan(input ir, input int n, input logic [31:0] din, output logic [31:0] dout);
      int i;
      dout = 32'h0;
      i_tst.step(1'b1, 1'b0, o);
      if (ir) i_tst.step(1'b1, 1'b0, o);
      i_tst.step(1'b0, 1'b0, o);
      i_tst.step(1'b0, 1'b0, o);
      // a longer low phase lets the output enable settle before it is looked at
      repeat (4) @(negedge i_clk_sys);
      chk(oe, 1'b1);
      for (i = 0; i < n; i++) begin
         i_tst.step(i == n - 1, din[i], o);
         dout[i] = o;
      end
      i_tst.step(1'b1, 1'b0, o);
      i_tst.step(1'b0, 1'b0, o);
      chk(oe, 1'b0);
      chk(state, `BSTI_TAP_IDLE);
   endtask
   always @(posedge i_clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      i_rst_b = 1'b0;
      repeat (12) @(negedge i_clk_sys);
      i_rst_b = 1'b1;
      chk({oe, instr}, {1'b0, `BSTI_OP_IDCODE});
      i_tst.o_trst_b = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      i_tst.step(1'b0, 1'b0, o);
      for (r = 0; r < 5; r++) begin
         scan(1'b1, 6, rows[r][9:4], d);
         chk(d[5:0], 6'h2D);
         chk(instr, rows[r][9:4]);
         chk({clamp, highz}, rows[r][3:2]);
         scan(1'b0, 2, 32'h1, d);
         chk(d[1:0], rows[r][1:0]);
      end
      // five high mode-select clocks must reach reset even from a loaded bypass
      scan(1'b1, 6, `BSTI_OP_BYPASS, d);
      repeat (5) i_tst.step(1'b1, 1'b0, o);
      chk(instr, `BSTI_OP_IDCODE);
      chk(state, `BSTI_TAP_RESET);
      i_tst.step(1'b0, 1'b0, o);
      scan(1'b0, 32, 32'h0, d);
      chk(d, ID);
      // a low enable must hide a whole test-clock cycle from the controller
      ce = 1'b0;
      i_tst.step(1'b1, 1'b0, o);
      ce = 1'b1;
      repeat (4) @(negedge i_clk_sys);
      chk(state, `BSTI_TAP_IDLE);
      scan(1'b1, 6, `BSTI_OP_CLAMP, d);
      i_tst.o_trst_b = 1'b0;
      repeat (10) @(negedge i_clk_sys);
      chk({instr, clamp}, {`BSTI_OP_IDCODE, 1'b0});
      final_report();
   end
endmodule // bsti_tap_tb_top

//--- bsti_tester.sv
// board tester model driving the test-port pins
`timescale 1ns/100ps
module bsti_tester (
   input  wire i_clk_sys,
   input  wire i_tdo,
   output reg  o_tck,
   output reg  o_tms,
   output reg  o_tdi,
   output reg  o_trst_b
);
   initial begin
      o_tck    = 1'b0;
      o_tms    = 1'b1;
      o_tdi    = 1'b1;
      o_trst_b = 1'b0;
   end
   // one tck period of 8 sys clocks; tdo taken just before the rise, after it settled
   task step(input m, input d, output o);
      begin
         o_tms = m;
         o_tdi = d;
         repeat (4) @(negedge i_clk_sys);
         o = i_tdo;
         o_tck = 1'b1;
         repeat (4) @(negedge i_clk_sys);
         o_tck = 1'b0;
      end
   endtask
endmodule // bsti_tester
